// ### rtl/ufc_uart.sv
`timescale 1ns/1ns
`include "ufc_cfg.svh"
// How it works
// - bit rate is 1 MHz divided by a 16-bit divisor
// - with refinement, rate is 16 MHz over divisor times refinement plus one
// - preset rates 4800 to 115200 selectable instead of divisor
// - optional odd or even parity generated and checked
// - five to eight data bits per character
// - one stop bit or a longer two-bit stop period
// - software sets the request-to-send level, first port four-wire only
// - transmit-empty interrupt when the last queued byte starts sending
// - receive-available interrupt while occupancy at or above trigger 1/4/8/14
// - timeout interrupt after four idle character times with data held
// - reading a character clears timeout and restarts its timer
// - line status interrupt on break, framing, parity or overrun
// - modem interrupt on clear-to-send change; current state readable, first port four-wire only
// - head byte sent automatically once the transmit line idles and, in four-wire mode, clear-to-send is high
// - transmit and receive FIFO levels are readable
// - line status shows receive data ready and transmit empty
// - received characters enter the receive FIFO automatically
// - first port defaults to four-wire and owns flow pins when enabled
// - second port has no four-wire flow control
module ufc_uart
  import ufc_pkg::*;
#(
  parameter bit FIRST_PORT = 1'b1,
  parameter int DEPTH      = `UFC_FIFO_DEPTH
)
(
  // clock and reset
  input  wire logic          clock_in,
  input  wire logic          rst_in,
  // configuration
  input  wire logic          enable_in,
  input  wire logic          flow_release_in,
  input  wire ufc_baud_t     baud_in,
  input  wire ufc_frame_t    frame_in,
  input  wire ufc_irq_en_t   irq_en_in,
  // transmit fifo write
  input  wire logic          tx_wr_in,
  input  wire logic [7:0]    tx_data_in,
  output logic               tx_ready_out,
  // receive fifo read
  input  wire logic          rx_rd_in,
  output logic [7:0]         rx_data_out,
  output logic               rx_valid_out,
  // status
  output logic [`UFC_LVL_W-1:0] tx_level_out,
  output logic [`UFC_LVL_W-1:0] rx_level_out,
  output logic               tx_empty_out,
  output ufc_line_err_t      line_err_out,
  output logic               cts_out,
  output ufc_irq_t           irq_out,
  // serial pins
  output logic               txd_out,
  input  wire logic          rxd_in,
  output logic               rts_out,
  output logic               rts_oe_out,
  input  wire logic          cts_in
);
  localparam int AW = $clog2(DEPTH);
  // ----------------------------------------
  // pin synchronisers and tick
  // ----------------------------------------
  logic [2:0] rx_sync_reg;
  logic [2:0] cts_sync_reg;
  logic       rx_line_reg;
  logic       cts_line_reg;
  logic       os_tick;
  logic       four_wire;
  assign four_wire = FIRST_PORT && enable_in && !flow_release_in;
  ufc_baud u_baud (
    .clock_in    (clock_in),
    .rst_in      (rst_in),
    .baud_in     (baud_in),
    .os_tick_out (os_tick)
  );
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rx_sync_reg  <= 3'h7;
      cts_sync_reg <= 3'h0;
      rx_line_reg  <= 1'b1;
      cts_line_reg <= 1'b0;
    end else begin
      rx_sync_reg  <= {rx_sync_reg[1:0], rxd_in};
      cts_sync_reg <= {cts_sync_reg[1:0], cts_in};
      if (rx_sync_reg[1] == rx_sync_reg[2])
        rx_line_reg <= rx_sync_reg[2];
      if (cts_sync_reg[1] == cts_sync_reg[2])
        cts_line_reg <= cts_sync_reg[2];
    end
  end

  // ----------------------------------------
  // fifos
  // ----------------------------------------
  logic [7:0]    tx_mem [DEPTH];
  logic [7:0]    rx_mem [DEPTH];
  logic [AW-1:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
  logic [AW:0]   tx_cnt_reg, rx_cnt_reg;
  logic          tx_push, tx_pop, rx_push, rx_pop;
  logic [7:0]    rx_char;
  logic          tx_full, rx_full;
  assign tx_full = (tx_cnt_reg == (AW+1)'(DEPTH));
  assign rx_full = (rx_cnt_reg == (AW+1)'(DEPTH));
  assign tx_push = tx_wr_in && !tx_full;
  assign rx_pop  = rx_rd_in && (rx_cnt_reg != '0);
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      tx_wp_reg  <= '0;
      tx_rp_reg  <= '0;
      rx_wp_reg  <= '0;
      rx_rp_reg  <= '0;
      tx_cnt_reg <= '0;
      rx_cnt_reg <= '0;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wp_reg] <= tx_data_in;
        tx_wp_reg         <= tx_wp_reg + 1'b1;
      end
      if (tx_pop)
        tx_rp_reg <= tx_rp_reg + 1'b1;
      tx_cnt_reg <= tx_cnt_reg + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
      if (rx_push) begin
        rx_mem[rx_wp_reg] <= rx_char;
        rx_wp_reg         <= rx_wp_reg + 1'b1;
      end
      if (rx_pop)
        rx_rp_reg <= rx_rp_reg + 1'b1;
      rx_cnt_reg <= rx_cnt_reg + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  typedef enum logic [2:0] {UFC_TX_IDLE, UFC_TX_START, UFC_TX_DATA, UFC_TX_PAR, UFC_TX_STOP}
    ufc_tx_state_t;
  ufc_tx_state_t tx_state_reg;
  logic [7:0]    tx_shift_reg;
  logic [2:0]    tx_bit_reg;
  logic [4:0]    tx_os_reg;
  logic          tx_par_reg;
  logic          tx_bit_end;
  logic          tx_allowed;
  logic [2:0]    last_bit;
  logic [4:0]    stop_os;
  assign last_bit   = 3'(`UFC_LEN_BASE) + 3'(frame_in.word_len) - 3'd1;
  assign stop_os    = frame_in.long_stop ? 5'h1F : 5'h0F;
  assign tx_bit_end = os_tick && (tx_os_reg == ((tx_state_reg == UFC_TX_STOP) ? stop_os : 5'h0F));
  assign tx_allowed = enable_in && (!four_wire || cts_line_reg);
  assign tx_pop     = (tx_state_reg == UFC_TX_IDLE) && (tx_cnt_reg != '0) && tx_allowed;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      tx_state_reg <= UFC_TX_IDLE;
      tx_shift_reg <= 8'h00;
      tx_bit_reg   <= 3'h0;
      tx_os_reg    <= 5'h00;
      tx_par_reg   <= 1'b0;
      txd_out      <= 1'b1;
    end else begin
      if (os_tick)
        tx_os_reg <= tx_bit_end ? 5'h00 : tx_os_reg + 5'h01;
      unique case (tx_state_reg)
        UFC_TX_IDLE: begin
          txd_out <= 1'b1;
          if (tx_pop) begin
            tx_shift_reg <= tx_mem[tx_rp_reg];
            tx_par_reg   <= frame_in.parity_odd;
            tx_os_reg    <= 5'h00;
            tx_bit_reg   <= 3'h0;
            tx_state_reg <= UFC_TX_START;
            txd_out      <= 1'b0;
          end
        end
        UFC_TX_START: if (tx_bit_end) begin
          tx_state_reg <= UFC_TX_DATA;
          txd_out      <= tx_shift_reg[0];
        end
        UFC_TX_DATA: if (tx_bit_end) begin
          tx_par_reg   <= tx_par_reg ^ tx_shift_reg[0];
          tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
          tx_bit_reg   <= tx_bit_reg + 3'h1;
          if (tx_bit_reg == last_bit) begin
            tx_state_reg <= frame_in.parity_en ? UFC_TX_PAR : UFC_TX_STOP;
            txd_out      <= frame_in.parity_en ? (tx_par_reg ^ tx_shift_reg[0]) : 1'b1;
          end else begin
            txd_out <= tx_shift_reg[1];
          end
        end
        UFC_TX_PAR: if (tx_bit_end) begin
          tx_state_reg <= UFC_TX_STOP;
          txd_out      <= 1'b1;
        end
        UFC_TX_STOP: if (tx_bit_end)
          tx_state_reg <= UFC_TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  typedef enum logic [2:0] {UFC_RX_IDLE, UFC_RX_START, UFC_RX_DATA, UFC_RX_PAR, UFC_RX_STOP}
    ufc_rx_state_t;
  ufc_rx_state_t rx_state_reg;
  logic [7:0]    rx_shift_reg;
  logic [2:0]    rx_bit_reg;
  logic [3:0]    rx_os_reg;
  logic          rx_par_reg;
  logic          rx_perr_reg;
  logic          rx_zero_reg;
  logic          rx_sample;
  logic          rx_done;
  logic          err_frame, err_par, err_brk, err_ovr;
  assign rx_sample = os_tick && (rx_os_reg == 4'h7);
  assign rx_done   = rx_sample && (rx_state_reg == UFC_RX_STOP);
  assign rx_push   = rx_done && !rx_full && enable_in;
  assign rx_char   = rx_shift_reg >> (3'd7 - last_bit);
  assign err_frame = rx_done && !rx_line_reg;
  assign err_brk   = err_frame && rx_zero_reg;
  assign err_par   = rx_done && rx_perr_reg;
  assign err_ovr   = rx_done && rx_full;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rx_state_reg <= UFC_RX_IDLE;
      rx_shift_reg <= 8'h00;
      rx_bit_reg   <= 3'h0;
      rx_os_reg    <= 4'h0;
      rx_par_reg   <= 1'b0;
      rx_perr_reg  <= 1'b0;
      rx_zero_reg  <= 1'b0;
    end else begin
      if (os_tick)
        rx_os_reg <= rx_os_reg + 4'h1;
      unique case (rx_state_reg)
        UFC_RX_IDLE: if (!rx_line_reg && enable_in) begin
          rx_state_reg <= UFC_RX_START;
          rx_os_reg    <= 4'h0;
        end
        UFC_RX_START: if (rx_sample) begin
          rx_state_reg <= rx_line_reg ? UFC_RX_IDLE : UFC_RX_DATA;
          rx_bit_reg   <= 3'h0;
          rx_par_reg   <= frame_in.parity_odd;
          rx_perr_reg  <= 1'b0;
          rx_zero_reg  <= 1'b1;
        end
        UFC_RX_DATA: if (rx_sample) begin
          rx_shift_reg <= {rx_line_reg, rx_shift_reg[7:1]};
          rx_par_reg   <= rx_par_reg ^ rx_line_reg;
          rx_zero_reg  <= rx_zero_reg & !rx_line_reg;
          rx_bit_reg   <= rx_bit_reg + 3'h1;
          if (rx_bit_reg == last_bit)
            rx_state_reg <= frame_in.parity_en ? UFC_RX_PAR : UFC_RX_STOP;
        end
        UFC_RX_PAR: if (rx_sample) begin
          rx_perr_reg  <= rx_par_reg != rx_line_reg;
          rx_zero_reg  <= rx_zero_reg & !rx_line_reg;
          rx_state_reg <= UFC_RX_STOP;
        end
        UFC_RX_STOP: if (rx_sample)
          rx_state_reg <= UFC_RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // timeout and interrupt conditions
  // ----------------------------------------
  logic [7:0]           tmo_os_reg;
  logic [2:0]           tmo_chr_reg;
  logic                 tmo_hit;
  logic [`UFC_LVL_W-1:0] trig;
  logic                 cts_prev_reg;
  logic                 tx_last_start;
  assign trig = (irq_en_in.rx_trig == 2'd0) ? `UFC_TRIG_1 :
                (irq_en_in.rx_trig == 2'd1) ? `UFC_TRIG_4 :
                (irq_en_in.rx_trig == 2'd2) ? `UFC_TRIG_8 : `UFC_TRIG_14;
  // character time of the longest frame, twelve bits of 16 ticks
  assign tmo_hit       = (tmo_chr_reg == 3'(`UFC_TMO_CHARS));
  assign tx_last_start = tx_pop && (tx_cnt_reg == (AW+1)'(1)) && !tx_push;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      tmo_os_reg   <= 8'h00;
      tmo_chr_reg  <= 3'h0;
      cts_prev_reg <= 1'b0;
      irq_out      <= '0;
      line_err_out <= '0;
    end else begin
      cts_prev_reg <= cts_line_reg;
      if (rx_push || rx_pop || rx_cnt_reg == '0) begin
        tmo_os_reg  <= 6'h00;
        tmo_chr_reg <= 3'h0;
      end else if (os_tick && !tmo_hit) begin
        if (tmo_os_reg == `UFC_CHAR_TICKS) begin
          tmo_os_reg  <= 8'h00;
          tmo_chr_reg <= tmo_chr_reg + 3'h1;
        end else begin
          tmo_os_reg <= tmo_os_reg + 8'h01;
        end
      end
      irq_out.tx_empty  <= irq_en_in.tx_empty_en &&
                           (tx_last_start || (irq_out.tx_empty && !tx_push));
      irq_out.rx_avail  <= irq_en_in.rx_avail_en &&
                           (`UFC_LVL_W'(rx_cnt_reg) >= trig);
      irq_out.timeout   <= irq_en_in.rx_avail_en && !rx_pop &&
                           (irq_out.timeout || tmo_hit);
      irq_out.line_stat <= irq_en_in.line_stat_en &&
                           (err_frame || err_par || err_ovr || irq_out.line_stat);
      irq_out.modem     <= irq_en_in.modem_en && four_wire &&
                           ((cts_line_reg != cts_prev_reg) || irq_out.modem);
      line_err_out      <= {err_brk, err_frame, err_par, err_ovr};
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      tx_ready_out <= 1'b0;
      rx_data_out  <= 8'h00;
      rx_valid_out <= 1'b0;
      tx_level_out <= '0;
      rx_level_out <= '0;
      tx_empty_out <= 1'b1;
      cts_out      <= 1'b0;
      rts_out      <= 1'b0;
      rts_oe_out   <= 1'b0;
    end else begin
      tx_ready_out <= !tx_full;
      rx_data_out  <= rx_mem[rx_rp_reg];
      rx_valid_out <= (rx_cnt_reg != '0);
      tx_level_out <= `UFC_LVL_W'(tx_cnt_reg);
      rx_level_out <= `UFC_LVL_W'(rx_cnt_reg);
      tx_empty_out <= (tx_cnt_reg == '0);
      cts_out      <= cts_line_reg && four_wire;
      rts_out      <= frame_in.rts_level && four_wire;
      rts_oe_out   <= four_wire;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_TX_HOLD: assert property (@(posedge clock_in) disable iff (rst_in)
    (four_wire && !cts_line_reg) |-> !tx_pop) else $error("transmit started without cts");
  AST_IDLE_HIGH: assert property (@(posedge clock_in) disable iff (rst_in)
    (tx_state_reg == UFC_TX_IDLE && !$past(tx_pop)) |-> txd_out) else $error("line not idle high");
  AST_START_LOW: assert property (@(posedge clock_in) disable iff (rst_in)
    tx_pop |=> !txd_out) else $error("start bit not low");
  AST_RX_AVAIL: assert property (@(posedge clock_in) disable iff (rst_in)
    (irq_en_in.rx_avail_en && `UFC_LVL_W'(rx_cnt_reg) >= trig) |=> irq_out.rx_avail)
    else $error("receive available missing");
  AST_TMO_CLR: assert property (@(posedge clock_in) disable iff (rst_in)
    rx_pop |=> !irq_out.timeout) else $error("timeout not cleared by read");
  AST_TX_EMPTY: assert property (@(posedge clock_in) disable iff (rst_in)
    (irq_en_in.tx_empty_en && tx_last_start) |=> irq_out.tx_empty) else $error("tx empty missing");
  AST_NO_FLOW2: assert property (@(posedge clock_in) disable iff (rst_in)
    !FIRST_PORT |-> !rts_oe_out && !irq_out.modem) else $error("second port flow control");
  AST_OVR: assert property (@(posedge clock_in) disable iff (rst_in)
    err_ovr |=> line_err_out.overrun) else $error("overrun not flagged");
endmodule

// ### rtl/ufc_cfg.svh
`ifndef UFC_CFG_SVH
`define UFC_CFG_SVH
// ----------------------------------------
// clocking and bit rate
// ----------------------------------------
`define UFC_CLK_HZ       100_000_000
`define UFC_REF_HZ       1_000_000
`define UFC_PER_HZ       16_000_000
`define UFC_REF_CYC      (`UFC_CLK_HZ / `UFC_REF_HZ)
`define UFC_PER_NUM      16'h0019
`define UFC_PER_DEN      16'h0004
`define UFC_DIV_W        16
`define UFC_CPB_W        8
// preset divisors on the 1 MHz reference, rounded to nearest
`define UFC_DIV_4800     16'h00D0
`define UFC_DIV_9600     16'h0068
`define UFC_DIV_19200    16'h0034
`define UFC_DIV_38400    16'h001A
`define UFC_DIV_76800    16'h000D
`define UFC_DIV_115200   16'h0009
// ----------------------------------------
// framing and fifo
// ----------------------------------------
`define UFC_FIFO_DEPTH   16
`define UFC_LVL_W        5
`define UFC_TMO_CHARS    4
// ticks in the longest character, less one
`define UFC_CHAR_TICKS   8'hBF
`define UFC_LEN_BASE     4'h5
`define UFC_TRIG_1       5'h01
`define UFC_TRIG_4       5'h04
`define UFC_TRIG_8       5'h08
`define UFC_TRIG_14      5'h0E
`endif

// ### rtl/ufc_pkg.sv
package ufc_pkg;
  typedef enum logic [2:0] {
    UFC_RATE_DIV, UFC_RATE_4800, UFC_RATE_9600, UFC_RATE_19200,
    UFC_RATE_38400, UFC_RATE_76800, UFC_RATE_115200
  } ufc_rate_t;

  typedef struct packed {
    ufc_rate_t   rate_sel;
    logic [15:0] divisor;
    logic        cpb_en;
    logic [7:0]  cpb;
  } ufc_baud_t;

  typedef struct packed {
    logic       parity_en;
    logic       parity_odd;
    logic [1:0] word_len;   // 0..3 = 5..8 bits
    logic       long_stop;
    logic       rts_level;
  } ufc_frame_t;

  typedef struct packed {
    logic       tx_empty_en;
    logic       rx_avail_en;
    logic       line_stat_en;
    logic       modem_en;
    logic [1:0] rx_trig;    // 1, 4, 8, 14
  } ufc_irq_en_t;

  typedef struct packed {
    logic tx_empty;
    logic rx_avail;
    logic timeout;
    logic line_stat;
    logic modem;
  } ufc_irq_t;

  typedef struct packed {
    logic brk;
    logic framing;
    logic parity;
    logic overrun;
  } ufc_line_err_t;
endpackage

// ### rtl/ufc_baud.sv
`timescale 1ns/1ns
`include "ufc_cfg.svh"
// ----------------------------------------
// bit tick generator, 16x oversampling tick
// ----------------------------------------
module ufc_baud
  import ufc_pkg::*;
(
  // clock and reset
  input  wire logic      clock_in,
  input  wire logic      rst_in,
  // configuration
  input  wire ufc_baud_t baud_in,
  // ticks
  output logic           os_tick_out
);
  logic [31:0] bit_cyc;
  logic [31:0] os_cyc;
  logic [31:0] cnt_reg;
  logic [15:0] div_eff;

  assign div_eff = (baud_in.rate_sel == UFC_RATE_4800)   ? `UFC_DIV_4800   :
                   (baud_in.rate_sel == UFC_RATE_9600)   ? `UFC_DIV_9600   :
                   (baud_in.rate_sel == UFC_RATE_19200)  ? `UFC_DIV_19200  :
                   (baud_in.rate_sel == UFC_RATE_38400)  ? `UFC_DIV_38400  :
                   (baud_in.rate_sel == UFC_RATE_76800)  ? `UFC_DIV_76800  :
                   (baud_in.rate_sel == UFC_RATE_115200) ? `UFC_DIV_115200 :
                   ((baud_in.divisor == 16'h0000) ? 16'h0001 : baud_in.divisor);

  // 1 MHz reference: 100 clocks per divisor step; 16 MHz: 6.25 clocks per step
  assign bit_cyc = baud_in.cpb_en ?
                   32'((32'(div_eff) * (32'(baud_in.cpb) + 32'd1) * 32'(`UFC_PER_NUM))
                       / 32'(`UFC_PER_DEN)) :
                   32'(div_eff) * 32'(`UFC_REF_CYC);
  assign os_cyc  = (bit_cyc >> 4) == 32'd0 ? 32'd1 : (bit_cyc >> 4);

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg     <= 32'h0000_0000;
      os_tick_out <= 1'b0;
    end else begin
      os_tick_out <= (cnt_reg + 32'd1 >= os_cyc);
      cnt_reg     <= (cnt_reg + 32'd1 >= os_cyc) ? 32'h0000_0000 : cnt_reg + 32'd1;
    end
  end
endmodule

// ### testbench/ufc_remote.sv
`timescale 1ns/1ns
// ----------------------------------------
// remote serial device
// ----------------------------------------
module ufc_remote #(
  parameter int BIT_CYC = 400
)
(
  // clock
  input  wire logic clock_in,
  // serial pins
  input  wire logic rxd_in,
  output logic      txd_out,
  output logic      rts_out
);
  initial begin
    txd_out = 1'b1;
    rts_out = 1'b1;
  end

  // flow control level seen as cts by the local side
  task automatic set_rts(input logic lvl);
    @(posedge clock_in);
    rts_out <= lvl;
  endtask

  // one frame: low start, data lsb first, parity when pe is set, high stop
  task automatic send(input logic [7:0] d, input int nb, input logic pe, input logic pb);
    logic [11:0] f;
    int          n;
    f = 12'h000;
    for (int i = 0; i < nb; i++) f[i+1] = d[i];
    n = nb + 1;
    if (pe) begin
      f[n] = pb;
      n++;
    end
    f[n] = 1'b1;
    for (int i = 0; i <= n; i++) begin
      @(posedge clock_in);
      txd_out <= f[i];
      repeat (BIT_CYC - 1) @(posedge clock_in);
    end
  endtask

  // sample a frame at mid bit, start bit in v[0]
  task automatic grab(input int n, output logic [12:0] v, output bit ok);
    v = 13'h0000;
    ok = 1'b0;
    for (int i = 0; i < 40000 && !ok; i++) begin
      @(posedge clock_in);
      ok = (rxd_in === 1'b0);
    end
    repeat (BIT_CYC / 2) @(posedge clock_in);
    // no wait after the last sample, so a following frame is not missed
    for (int i = 0; i < n; i++) begin
      v[i] = rxd_in;
      if (i < n - 1) repeat (BIT_CYC) @(posedge clock_in);
    end
  endtask
endmodule

// ### testbench/ufc_uart_tb.sv
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, e); end end
module ufc_uart_tb;
  import ufc_pkg::*;
  localparam int BIT_CYC = 400;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic          clock_in = 1'b0, rst_in = 1'b1, enable_in = 1'b0, flow_release_in = 1'b0;
  logic          tx_wr_in = 1'b0, rx_rd_in = 1'b0, rxd, cts, seen_par = 1'b0;
  logic [7:0]    tx_data_in = 8'h00, rx_data;
  ufc_baud_t     baud_in = '{UFC_RATE_DIV, 16'h0004, 1'b0, 8'h00};
  ufc_frame_t    frame_in = '{1'b0, 1'b0, 2'd3, 1'b0, 1'b1};
  ufc_irq_en_t   irq_en_in = '{1'b1, 1'b1, 1'b1, 1'b1, 2'd1};
  logic [4:0]    tx_level, rx_level;
  logic          tx_ready, rx_valid, tx_empty, cts_o, txd, rts, rts_oe;
  ufc_line_err_t line_err;
  ufc_irq_t      irq;
  logic [12:0]   exp;
  int            n_errors = 0, cmp_count = 0;

  always #5 clock_in = ~clock_in;
  always @(posedge clock_in) if (line_err.parity === 1'b1) seen_par <= 1'b1;

  ufc_uart u_ufc_uart (.clock_in(clock_in), .rst_in(rst_in), .enable_in(enable_in),
    .flow_release_in(flow_release_in), .baud_in(baud_in), .frame_in(frame_in),
    .irq_en_in(irq_en_in), .tx_wr_in(tx_wr_in), .tx_data_in(tx_data_in),
    .tx_ready_out(tx_ready), .rx_rd_in(rx_rd_in), .rx_data_out(rx_data),
    .rx_valid_out(rx_valid), .tx_level_out(tx_level), .rx_level_out(rx_level),
    .tx_empty_out(tx_empty), .line_err_out(line_err), .cts_out(cts_o), .irq_out(irq),
    .txd_out(txd), .rxd_in(rxd), .rts_out(rts), .rts_oe_out(rts_oe), .cts_in(cts));
  ufc_remote #(.BIT_CYC(BIT_CYC)) u_ufc_remote (.clock_in(clock_in), .rxd_in(txd),
    .txd_out(rxd), .rts_out(cts));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic test_done();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clock_in);
    tx_wr_in <= 1'b1;
    tx_data_in <= d;
    @(posedge clock_in);
    tx_wr_in <= 1'b0;
  endtask
  task automatic rd();
    @(posedge clock_in);
    rx_rd_in <= 1'b1;
    @(posedge clock_in);
    rx_rd_in <= 1'b0;
    repeat (3) @(posedge clock_in);
  endtask
  task automatic chk_frame(input int n, input logic [12:0] e);
    logic [12:0] v;
    bit          ok;
    u_ufc_remote.grab(n, v, ok);
    if (!ok) begin
      n_errors++;
      test_done();
    end
    `CHK(v, e)
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_tx_frames();
    logic [7:0] d;
    logic       p;
    int         k;
    for (int l = 0; l < 4; l++) begin
      d = 8'hA5 ^ 8'(l);
      @(posedge clock_in);
      frame_in <= '{l[0], l[1], l[1:0], (l == 3), 1'b1};
      exp = 13'h0000;
      p = l[1];
      for (int i = 0; i < 5 + l; i++) begin
        exp[i+1] = d[i];
        p ^= d[i];
      end
      k = 6 + l;
      if (l[0]) begin
        exp[k] = p;
        k++;
      end
      exp[k] = 1'b1;
      exp[k+1] = 1'b1;
      wr(d);
      chk_frame(k + 2, exp);
      `CHK(irq.tx_empty, 1'b1)
      `CHK(tx_empty, 1'b1)
      repeat (BIT_CYC) @(posedge clock_in);
    end
  endtask

  task automatic t_rx();
    @(posedge clock_in);
    frame_in <= '{1'b1, 1'b0, 2'd3, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++) begin
      u_ufc_remote.send(8'h30 + 8'(i), 8, 1'b1, ^(8'h30 + 8'(i)));
      repeat (BIT_CYC) @(posedge clock_in);
      if (i == 2) `CHK(irq.rx_avail, 1'b0)
    end
    `CHK(rx_level, 5'd4)
    `CHK(irq.rx_avail, 1'b1)
    `CHK(rx_valid, 1'b1)
    `CHK(seen_par, 1'b0)
    for (int i = 0; i < 4; i++) begin
      `CHK(rx_data, 8'h30 + 8'(i))
      rd();
      if (i == 0) `CHK(irq.rx_avail, 1'b0)
    end
    u_ufc_remote.send(8'h5A, 8, 1'b1, ~^8'h5A);
    repeat (BIT_CYC) @(posedge clock_in);
    `CHK(seen_par, 1'b1)
    `CHK(irq.line_stat, 1'b1)
  endtask

  task automatic t_timeout();
    int n;
    for (int i = 0; i < 4; i++) if (rx_valid === 1'b1) rd();
    u_ufc_remote.send(8'hC3, 8, 1'b1, ^8'hC3);
    `CHK(irq.timeout, 1'b0)
    n = 0;
    while (irq.timeout !== 1'b1 && n < 24000) begin
      @(posedge clock_in);
      n++;
    end
    `CHK((n > 4 * 12 * BIT_CYC - BIT_CYC && n < 4 * 12 * BIT_CYC + BIT_CYC), 1'b1)
    rd();
    `CHK(irq.timeout, 1'b0)
  endtask

  task automatic t_flow();
    @(posedge clock_in);
    frame_in <= '{1'b0, 1'b0, 2'd3, 1'b0, 1'b1};
    irq_en_in.modem_en <= 1'b0;
    repeat (4) @(posedge clock_in);
    irq_en_in.modem_en <= 1'b1;
    repeat (4) @(posedge clock_in);
    `CHK(irq.modem, 1'b0)
    u_ufc_remote.set_rts(1'b0);
    repeat (10) @(posedge clock_in);
    `CHK(cts_o, 1'b0)
    `CHK(irq.modem, 1'b1)
    `CHK({rts_oe, rts}, 2'b11)
    wr(8'h11);
    wr(8'h22);
    repeat (3 * BIT_CYC) @(posedge clock_in);
    `CHK(txd, 1'b1)
    `CHK(tx_level, 5'd2)
    `CHK(tx_empty, 1'b0)
    `CHK(tx_ready, 1'b1)
    u_ufc_remote.set_rts(1'b1);
    chk_frame(10, {1'b1, 8'h11, 1'b0});
    chk_frame(10, {1'b1, 8'h22, 1'b0});
    @(posedge clock_in);
    enable_in <= 1'b0;
    flow_release_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    enable_in <= 1'b1;
    repeat (10) @(posedge clock_in);
    `CHK({rts_oe, cts_o}, 2'b00)
  endtask

  task automatic t_rates();
    int n;
    @(posedge clock_in);
    baud_in <= '{UFC_RATE_DIV, 16'h0002, 1'b1, 8'h1F};
    wr(8'h96);
    chk_frame(10, {1'b1, 8'h96, 1'b0});
    repeat (BIT_CYC) @(posedge clock_in);
    baud_in <= '{UFC_RATE_76800, 16'h0002, 1'b0, 8'h00};
    wr(8'hF0);
    n = 0;
    while (txd !== 1'b0 && n < 4000) begin
      @(posedge clock_in);
      n++;
    end
    n = 0;
    while (txd === 1'b0 && n < 8000) begin
      @(posedge clock_in);
      n++;
    end
    // start plus four zero bits at 76800 bit/s, within two percent
    `CHK((n > 6380 && n < 6640), 1'b1)
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    enable_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    t_tx_frames();
    t_rx();
    t_timeout();
    t_flow();
    t_rates();
    test_done();
  end
endmodule
